/* rtl/lpi_defs.vh */
// Constants for the LED intensity block: register offsets,
// field positions, reset values and oscillator timing.
// Assumes a 200 MHz system clock.
`ifndef LPI_DEFS_VH
`define LPI_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LPI_ADDR_W 8
`define LPI_ADDR_MASTER_AUX 8'h0e
`define LPI_ADDR_LINE10 8'h10
`define LPI_ADDR_STATUS 8'h20
`define LPI_ADDR_PHASE 8'h21

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LPI_HI_MSB 7
`define LPI_HI_LSB 4
`define LPI_LO_MSB 3
`define LPI_LO_LSB 0
`define LPI_ST_RUN 0
`define LPI_ST_PIN0 1
`define LPI_ST_PIN1 2
`define LPI_ST_AUX 3

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define LPI_RST_MASTER_AUX 8'h00
`define LPI_RST_LINE10 8'h00
`define LPI_CODE_OFF 4'h0
`define LPI_CODE_FULL 4'hf
`define LPI_SLOT_LAST 4'he
`define LPI_STEP_LAST 4'hf

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LPI_CLK_NS 5
`define LPI_STEP_NS 160
`define LPI_STEP_CYC (`LPI_STEP_NS / `LPI_CLK_NS)

`endif

/* rtl/lpi_tick_gen.v */
// Oscillator step tick for the intensity block.
// Assumes run_i is a level; clearing it stops and rewinds the divider.
`timescale 1ns/100ps
`default_nettype none

module lpi_tick_gen #(
    parameter STEP_CYC = 32,
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    output reg tick_o
);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    localparam integer LAST_INT = STEP_CYC - 1;
    localparam [CNT_W-1:0] CNT_LAST = LAST_INT[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_reg;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule // lpi_tick_gen

`default_nettype wire

/* rtl/lpi_duty_cmp.v */
// Duty decision for one output from its 4-bit code.
// Assumes step_i runs 0..15 inside each master slot.
`timescale 1ns/100ps
`default_nettype none

module lpi_duty_cmp (
    input wire run_i,
    input wire window_i,
    input wire [3:0] code_i,
    input wire [3:0] step_i,
    output wire active_o
);

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    // Code n is on for n+1 of 16 steps; all ones never switches while window_i is high
    wire full_w;
    wire part_w;

    assign full_w = (code_i == 4'hf);
    assign part_w = (step_i <= code_i);
    assign active_o = run_i & window_i & (full_w | part_w);

endmodule // lpi_duty_cmp

`default_nettype wire

/* rtl/lpi_top.v */
// LED intensity control: master/aux and line 1/0 intensity registers,
// master-gated PWM oscillator, three open-drain outputs.
// Assumes a plain register port master and synchronous pin inputs.
//
// Behaviour
// - Register 0x0e holds the master duty in bits 7..4 and the aux duty in bits 3..0.
// - A master code of zero means 0/15: every output sits static with no PWM.
// - A master code of zero stops the oscillator; a nonzero write restarts it.
// - Master codes 1 to 14 give a duty of code fifteenths.
// - Master code all ones gives full 15/15 duty.
// - Aux codes 0 to 14 give a duty of code plus one sixteenths.
// - Aux code all ones gives 16/16, a static level with no switching inside each open master slot.
// - The line register holds line 1 duty in bits 7..4 and line 0 duty in bits 3..0.
// - Line codes 0 to 14 give a duty of code plus one sixteenths.
// - Writes load and reads return all eight stored bits unchanged.
// - The line register reads back with both fields in their written positions.
// - Line code all ones gives 16/16, a static level with no switching inside each open master slot.
//
// Design decision made here: the strobed register port.
`include "lpi_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module lpi_top #(
    parameter STEP_CYC = `LPI_STEP_CYC,
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire [`LPI_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire port_line_0_i,
    output reg port_line_0_o,
    output reg port_line_0_oe_o,
    input wire port_line_1_i,
    output reg port_line_1_o,
    output reg port_line_1_oe_o,
    input wire aux_output_i,
    output reg aux_output_o,
    output reg aux_output_oe_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [3:0] hi_nib;
        input [7:0] v;
        begin
            hi_nib = v[`LPI_HI_MSB:`LPI_HI_LSB];
        end
    endfunction

    function [3:0] lo_nib;
        input [7:0] v;
        begin
            lo_nib = v[`LPI_LO_MSB:`LPI_LO_LSB];
        end
    endfunction

    function hit;
        input [`LPI_ADDR_W-1:0] a;
        input [`LPI_ADDR_W-1:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    function [3:0] inc4;
        input [3:0] v;
        begin
            inc4 = v + 4'h1;
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg [7:0] master_aux_reg;
    reg [7:0] master_aux_next;
    reg [7:0] line10_reg;
    reg [7:0] line10_next;
    reg [7:0] rdata_next;
    reg [3:0] slot_reg;
    reg [3:0] slot_next;
    reg [3:0] step_reg;
    reg [3:0] step_next;
    reg run_reg;
    reg pin0_reg;
    reg pin1_reg;
    reg pin_aux_reg;
    reg [7:0] status_word;

    wire [3:0] master_code;
    wire [3:0] aux_code;
    wire [3:0] line0_code;
    wire [3:0] line1_code;
    wire run_w;
    wire tick_w;
    wire window_w;
    wire line0_act;
    wire line1_act;
    wire aux_act;
    wire [7:0] phase_word;
    wire sel_master_aux;
    wire sel_line10;
    wire step_wrap;
    wire slot_wrap;

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    assign master_code = hi_nib(master_aux_reg);
    assign aux_code = lo_nib(master_aux_reg);
    assign line1_code = hi_nib(line10_reg);
    assign line0_code = lo_nib(line10_reg);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Decode once so each write compare stays in one place
    assign sel_master_aux = hit(addr_i, `LPI_ADDR_MASTER_AUX);
    assign sel_line10 = hit(addr_i, `LPI_ADDR_LINE10);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @* begin
        master_aux_next = master_aux_reg;
        line10_next = line10_reg;
        if (wr_i) begin
            if (sel_master_aux) begin
                master_aux_next = wdata_i;
            end
            if (sel_line10) begin
                line10_next = wdata_i;
            end
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            master_aux_reg <= `LPI_RST_MASTER_AUX;
            line10_reg <= `LPI_RST_LINE10;
        end else begin
            master_aux_reg <= master_aux_next;
            line10_reg <= line10_next;
        end
    end

    // ------------------------------------------------------------
    // Readback words
    // ------------------------------------------------------------
    // Pins read through their pull-ups, so a released line shows 1
    always @* begin
        status_word = 8'h00;
        status_word[`LPI_ST_RUN] = run_reg;
        status_word[`LPI_ST_PIN0] = pin0_reg;
        status_word[`LPI_ST_PIN1] = pin1_reg;
        status_word[`LPI_ST_AUX] = pin_aux_reg;
    end

    assign phase_word = {slot_reg, step_reg};

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Data stands only in the cycle after the strobe; zero otherwise
    always @* begin
        rdata_next = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `LPI_ADDR_MASTER_AUX: begin
                    rdata_next = master_aux_reg;
                end
                `LPI_ADDR_LINE10: begin
                    rdata_next = line10_reg;
                end
                `LPI_ADDR_STATUS: begin
                    rdata_next = status_word;
                end
                `LPI_ADDR_PHASE: begin
                    rdata_next = phase_word;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // Pins are synchronous; one stage only for readback timing
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin0_reg <= 1'b0;
            pin1_reg <= 1'b0;
            pin_aux_reg <= 1'b0;
        end else begin
            pin0_reg <= port_line_0_i;
            pin1_reg <= port_line_1_i;
            pin_aux_reg <= aux_output_i;
        end
    end

    // ------------------------------------------------------------
    // Oscillator gate
    // ------------------------------------------------------------
    // Zero master code stops everything; a nonzero code restarts
    // from slot 0 step 0, so a new cycle never starts mid-window.
    assign run_w = (master_code != `LPI_CODE_OFF);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_w;
        end
    end

    lpi_tick_gen #(
        .STEP_CYC(STEP_CYC),
        .CNT_W(CNT_W)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_reg),
        .tick_o(tick_w)
    );

    // ------------------------------------------------------------
    // Slot and step sequencer
    // ------------------------------------------------------------
    // 15 master slots of 16 steps each: master divides by 15,
    // lines and aux by 16 within one slot.
    assign step_wrap = (step_reg == `LPI_STEP_LAST);
    assign slot_wrap = (slot_reg == `LPI_SLOT_LAST);

    always @* begin
        slot_next = slot_reg;
        step_next = step_reg;
        if (!run_reg) begin
            slot_next = 4'h0;
            step_next = 4'h0;
        end else if (tick_w) begin
            if (step_wrap) begin
                step_next = 4'h0;
                if (slot_wrap) begin
                    slot_next = 4'h0;
                end else begin
                    slot_next = inc4(slot_reg);
                end
            end else begin
                step_next = inc4(step_reg);
            end
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_reg <= 4'h0;
            step_reg <= 4'h0;
        end else begin
            slot_reg <= slot_next;
            step_reg <= step_next;
        end
    end

    // ------------------------------------------------------------
    // Master window
    // ------------------------------------------------------------
    // Slots below the code are open: 1..14 give code/15, 15 gives all
    assign window_w = (slot_reg < master_code);

    // ------------------------------------------------------------
    // Per-output duty
    // ------------------------------------------------------------
    lpi_duty_cmp u_line0 (
        .run_i(run_reg),
        .window_i(window_w),
        .code_i(line0_code),
        .step_i(step_reg),
        .active_o(line0_act)
    );

    lpi_duty_cmp u_line1 (
        .run_i(run_reg),
        .window_i(window_w),
        .code_i(line1_code),
        .step_i(step_reg),
        .active_o(line1_act)
    );

    lpi_duty_cmp u_aux (
        .run_i(run_reg),
        .window_i(window_w),
        .code_i(aux_code),
        .step_i(step_reg),
        .active_o(aux_act)
    );

    // ------------------------------------------------------------
    // Open-drain outputs
    // ------------------------------------------------------------
    // Active means sink low; with run low every enable stays off,
    // a static released level.
    localparam SINK_LEVEL = 1'b0;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_line_0_o <= 1'b0;
            port_line_1_o <= 1'b0;
            aux_output_o <= 1'b0;
        end else begin
            port_line_0_o <= SINK_LEVEL;
            port_line_1_o <= SINK_LEVEL;
            aux_output_o <= SINK_LEVEL;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_line_0_oe_o <= 1'b0;
            port_line_1_oe_o <= 1'b0;
            aux_output_oe_o <= 1'b0;
        end else begin
            port_line_0_oe_o <= line0_act;
            port_line_1_oe_o <= line1_act;
            aux_output_oe_o <= aux_act;
        end
    end

endmodule // lpi_top

`default_nettype wire

/* bench/lpi_pin_load.sv */
// Pull-up load on the three open-drain pins.
// Assumes oe high means the block pulls the pin low.
`timescale 1ns/100ps
`default_nettype none
module lpi_pin_load (
    input wire logic [2:0] oe_i,
    input wire logic [2:0] drv_i,
    output wire logic [2:0] pin_o
);
    // Released pins rise through the resistor, never float
    assign pin_o = (~oe_i) | drv_i;
endmodule // lpi_pin_load
`default_nettype wire

/* bench/lpi_props.sv */
// Checker for the intensity block, on the top ports only.
// Assumes reads and writes never share a cycle.
`timescale 1ns/100ps
`default_nettype none
module lpi_props #(
    parameter STEP_CYC = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic port_line_0_oe_o,
    input wire logic port_line_1_oe_o,
    input wire logic aux_output_oe_o
);
    logic [7:0] ma_reg;
    logic [7:0] ln_reg;
    logic [15:0] gap_reg;
    logic [15:0] hi_reg;
    // ------
    // Shadow state
    // ------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ma_reg <= 8'h00;
            ln_reg <= 8'h00;
            gap_reg <= 16'h0000;
            hi_reg <= 16'h0000;
        end else begin
            if (wr_i && addr_i == 8'h0e) begin
                ma_reg <= wdata_i;
            end
            if (wr_i && addr_i == 8'h10) begin
                ln_reg <= wdata_i;
            end
            // Saturates so long idle runs stay settled
            gap_reg <= wr_i ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hffff};
            hi_reg <= aux_output_oe_o ? hi_reg + 16'h0001 : 16'h0000;
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(a);
        rd_i && addr_i == a;
    endsequence
    // One slot of 16 steps after the last write, master at full
    sequence s_full;
        gap_reg > 16 * STEP_CYC + 4 && ma_reg[7:4] == 4'hf;
    endsequence
    AST_RD_MASTER: assert property (
        s_rd(8'h0e) |=> rdata_o == $past(ma_reg))
        else $error("master register read back wrong");
    AST_RD_LINE: assert property (
        s_rd(8'h10) |=> rdata_o == $past(ln_reg))
        else $error("line register read back wrong");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    AST_RD_UNMAPPED: assert property (
        rd_i && !(addr_i inside {8'h0e, 8'h10, 8'h20, 8'h21}) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_OFF_STATIC: assert property (
        (ma_reg[7:4] == 4'h0) [*4] |-> !(port_line_0_oe_o | port_line_1_oe_o | aux_output_oe_o))
        else $error("output active with master off");
    AST_RUN_FLAG: assert property (
        s_rd(8'h20) ##0 gap_reg > 16'h0003 |=> rdata_o[0] == ($past(ma_reg) > 8'h0f))
        else $error("oscillator state wrong");
    AST_AUX_FULL: assert property (
        s_full ##0 ma_reg[3:0] == 4'hf |-> aux_output_oe_o)
        else $error("aux not static at full");
    AST_LINE1_FULL: assert property (
        s_full ##0 ln_reg[7:4] == 4'hf |-> port_line_1_oe_o)
        else $error("line 1 not static at full");
    AST_AUX_PULSE: assert property (
        s_full ##0 ma_reg[3:0] == 4'h0 |-> hi_reg <= STEP_CYC)
        else $error("aux pulse too long");
endmodule // lpi_props
bind lpi_top lpi_props #(.STEP_CYC(STEP_CYC)) props_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port_line_0_oe_o(port_line_0_oe_o), .port_line_1_oe_o(port_line_1_oe_o),
    .aux_output_oe_o(aux_output_oe_o));
`default_nettype wire

/* bench/lpi_top_tb_top.sv */
// Bench for the intensity block: register tasks and duty counts.
// Assumes a pull-up on every pin and a short step divider.
`timescale 1ns/100ps
`default_nettype none
module lpi_top_tb_top;
    localparam int STEP = 2;
    localparam int PER = 15 * 16 * STEP;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    wire [7:0] rdata_o;
    wire [2:0] oe;
    wire [2:0] drv;
    wire [2:0] pin;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] tab [7] = '{16'h000f, 16'h10ef, 16'he730, 16'hffff, 16'hf00f, 16'h055a,
        16'h9c21};
    always #2.5 clk_i = ~clk_i;
    lpi_top #(.STEP_CYC(STEP)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .port_line_0_i(pin[0]), .port_line_0_o(drv[0]), .port_line_0_oe_o(oe[0]),
        .port_line_1_i(pin[1]), .port_line_1_o(drv[1]), .port_line_1_oe_o(oe[1]),
        .aux_output_i(pin[2]), .aux_output_o(drv[2]), .aux_output_oe_o(oe[2]));
    lpi_pin_load load_u (.oe_i(oe), .drv_i(drv), .pin_o(pin));
    // ------
    // Tasks
    // ------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Idle edge after each strobe so no signal is set twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask
    task automatic duty(input logic [7:0] ma, input logic [7:0] ln);
        int n [3];
        int cd [3];
        int m;
        logic [7:0] v;
        m = ma[7:4];
        cd = '{ln[3:0], ln[7:4], ma[3:0]};
        n = '{0, 0, 0};
        wr(8'h0e, ma);
        wr(8'h10, ln);
        repeat (8) @(posedge clk_i);
        rd(8'h20, v);
        chk(v & ((m == 0 || ma == ln) ? 8'hff : 8'h01),
            (m == 0) ? 8'h0e : 8'h01);
        // Any window of one full period holds the same on time
        repeat (PER) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 3; i++) begin
                n[i] += oe[i];
            end
        end
        @(posedge clk_i);
        for (int i = 0; i < 3; i++) begin
            chk(16'(n[i]),
                16'(m * STEP * (cd[i] == 15 ? 16 : cd[i] + 1)));
        end
    endtask
    // ------
    // Sequence
    // ------
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        // Normal run is near 3500 cycles
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(8'h0e, 8'h00);
        rdchk(8'h10, 8'h00);
        rdchk(8'h20, 8'h0e);
        rdchk(8'h21, 8'h00);
        wr(8'h0e, 8'hf7);
        wr(8'h10, 8'h5a);
        rdchk(8'h0e, 8'hf7);
        rdchk(8'h10, 8'h5a);
        wr(8'h33, 8'hff);
        rdchk(8'h33, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            duty(tab[i][15:8], tab[i][7:0]);
        end
        $display("test duty done");
        end_sim();
    end
endmodule // lpi_top_tb_top
`default_nettype wire
